// File: logic/wdrw_pkg.sv
// Package for the windowed watchdog: register offsets, option fields,
// reload counts and timing constants.
// Assumes a byte-wide register port with 20-bit addresses.
package wdrw_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [19:0] WDRW_OFF_DETECT   = 20'h0002c;
   localparam logic [19:0] WDRW_OFF_PROTECT  = 20'h0037c;
   localparam logic [19:0] WDRW_OFF_REFRESH  = 20'h0037d;
   localparam logic [19:0] WDRW_OFF_START    = 20'h0037e;
   localparam logic [19:0] WDRW_OFF_READOUT  = 20'h0037f;
   localparam logic [19:0] WDRW_OFF_OPT_TWO  = 20'hfffdb;
   localparam logic [19:0] WDRW_OFF_OPT_ONE  = 20'hfffff;
   localparam logic [19:0] WDRW_OFF_IRQ_MASK = 20'h00380;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int WDRW_DETECT_BIT     = 3;
   localparam int WDRW_PROTECT_BIT    = 7;
   localparam int WDRW_AUTO_START_BIT = 0;
   localparam int WDRW_PROT_INIT_BIT  = 1;
   localparam int WDRW_RELOAD_LSB     = 0;
   localparam int WDRW_DUTY_LSB       = 2;

   // ----------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------
   localparam logic [13:0] WDRW_RELOAD_0 = 14'h03ff;
   localparam logic [13:0] WDRW_RELOAD_1 = 14'h0fff;
   localparam logic [13:0] WDRW_RELOAD_2 = 14'h1fff;
   localparam logic [13:0] WDRW_RELOAD_3 = 14'h3fff;
   localparam logic [7:0]  WDRW_REFRESH_FIRST  = 8'h00;
   localparam logic [7:0]  WDRW_REFRESH_SECOND = 8'hff;
   localparam logic [7:0]  WDRW_OPT_TWO_RSVD   = 8'hf0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int WDRW_SYS_CLK_KHZ = 125000;
   localparam int WDRW_OSC_KHZ     = 125;
   localparam int WDRW_OSC_DIV     = WDRW_SYS_CLK_KHZ / WDRW_OSC_KHZ;
endpackage : wdrw_pkg

// File: logic/wdrw_watchdog.sv
// Windowed watchdog timer with protect mode, refresh window and
// software or automatic start.
// Assumes synchronous byte-wide register port; option bytes arrive as
// stable inputs from nonvolatile storage.
//
// Contract
// - In protect mode the counter is clocked by the dedicated 125 kHz tick.
// - Reload select 00/01/10/11 gives 03FFh/0FFFh/1FFFh/3FFFh.
// - Duty field 00/01/10/11 permits refresh in 25/50/75/100 percent.
// - Writing 00h then FFh to the refresh register reloads the counter.
// - Auto start select 0 starts counting after reset, 1 keeps it stopped.
// - Any write to the start register starts counting, except in the boot cycle right after reset.
// - Without protect mode the readout gives counter bits 10 down to 5.
// - In protect mode the readout slice follows the reload select field.
// - Underflow sets the detection flag at bit 3 of the status register.
// - Bit 7 of the protect control register enables protect mode.
// - Protect initial state 0 makes protect mode active from reset.
module wdrw_watchdog #(
   parameter int OSC_DIV = wdrw_pkg::WDRW_OSC_DIV
) (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [19:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [7:0]  rdata,
   input  wire logic [7:0]  first_option_byte,
   input  wire logic [7:0]  second_option_byte,
   output logic             wdt_reset_req,
   output logic             irq
);
   import wdrw_pkg::*;

   // Elaboration check: the tick divider is a 16-bit counter.
   generate
      if (OSC_DIV < 1 || OSC_DIV > 65535) begin : g_bad_div
         $error("OSC_DIV out of range");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire wr_detect  = wr_stb && addr == WDRW_OFF_DETECT;
   wire wr_protect = wr_stb && addr == WDRW_OFF_PROTECT;
   wire wr_refresh = wr_stb && addr == WDRW_OFF_REFRESH;
   wire wr_start   = wr_stb && addr == WDRW_OFF_START;
   wire wr_mask    = wr_stb && addr == WDRW_OFF_IRQ_MASK;
   wire [1:0] reload_sel = second_option_byte[WDRW_RELOAD_LSB +: 2];
   wire [1:0] duty_sel   = second_option_byte[WDRW_DUTY_LSB +: 2];

   function automatic logic [13:0] reload_of(input logic [1:0] s);
      unique case (s)
         2'h0: reload_of = WDRW_RELOAD_0;
         2'h1: reload_of = WDRW_RELOAD_1;
         2'h2: reload_of = WDRW_RELOAD_2;
         2'h3: reload_of = WDRW_RELOAD_3;
      endcase
   endfunction : reload_of

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic        protect_mode_enable;
   logic        running;
   logic        armed;
   logic        boot;
   logic [13:0] count;
   logic [15:0] osc_cnt;
   logic        underflow_detect_flag;
   logic        irq_mask;

   wire [13:0] reload_val = reload_of(reload_sel);
   wire        osc_tick   = osc_cnt == 16'(OSC_DIV - 1);
   wire        src_tick   = protect_mode_enable ? osc_tick : 1'b1;
   wire        dec        = running && src_tick;
   wire        underflow  = dec && count == 14'h0000;
   // Window: refresh allowed once count is at or below fraction of reload.
   wire [15:0] win_lim    = 16'(({2'h0, reload_val} * ({14'h0, duty_sel}
                            + 16'h1)) >> 2);
   wire        in_window  = {2'h0, count} <= win_lim;
   wire        refresh_ok = wr_refresh && wdata == WDRW_REFRESH_SECOND
                            && armed && in_window;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         boot <= 1'b1;
         protect_mode_enable <= 1'b0;
         running <= 1'b0;
      end else begin
         boot <= 1'b0;
         if (boot) begin
            protect_mode_enable <=
               !first_option_byte[WDRW_PROT_INIT_BIT];
            running <= !first_option_byte[WDRW_AUTO_START_BIT];
         end else begin
            if (wr_protect) begin
               protect_mode_enable <= wdata[WDRW_PROTECT_BIT];
            end
            if (wr_start) begin
               running <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || osc_tick) begin
         osc_cnt <= 16'h0000;
      end else begin
         osc_cnt <= osc_cnt + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         count <= WDRW_RELOAD_3;
         armed <= 1'b0;
      end else begin
         if (wr_refresh) begin
            armed <= wdata == WDRW_REFRESH_FIRST;
         end
         if (boot || refresh_ok || underflow) begin
            count <= reload_val;
         end else if (dec) begin
            count <= count - 14'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status, mask and interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         underflow_detect_flag <= 1'b0;
         irq_mask <= 1'b0;
         wdt_reset_req <= 1'b0;
      end else begin
         wdt_reset_req <= underflow;
         if (underflow) begin
            underflow_detect_flag <= 1'b1;
         end else if (wr_detect && wdata[WDRW_DETECT_BIT]) begin
            underflow_detect_flag <= 1'b0;
         end
         if (wr_mask) begin
            irq_mask <= wdata[WDRW_DETECT_BIT];
         end
      end
   end

   assign irq = underflow_detect_flag && irq_mask;

   // ----------------------------------------------------------------
   // Readback
   // ----------------------------------------------------------------
   logic [5:0] slice;
   always_comb begin
      if (!protect_mode_enable) begin
         slice = count[10:5];
      end else begin
         unique case (reload_sel)
            2'h0: slice = count[5:0];
            2'h1: slice = count[8:3];
            2'h2: slice = count[9:4];
            2'h3: slice = count[10:5];
         endcase
      end
   end

   wire [7:0] rd_mux =
      addr == WDRW_OFF_DETECT  ? 8'({underflow_detect_flag, 3'h0}) :
      addr == WDRW_OFF_PROTECT ? {protect_mode_enable, 7'h00} :
      addr == WDRW_OFF_READOUT ? {2'h0, slice} :
      addr == WDRW_OFF_IRQ_MASK ? 8'({irq_mask, 3'h0}) :
      addr == WDRW_OFF_OPT_TWO ? second_option_byte :
      addr == WDRW_OFF_OPT_ONE ? first_option_byte : 8'h00;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd_stb ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_flag_set;
      @(posedge sys_clk) disable iff (srst)
      underflow |=> underflow_detect_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("flag not set on underflow");

   property p_reload_on_refresh;
      @(posedge sys_clk) disable iff (srst)
      refresh_ok && !boot |=> count == $past(reload_val);
   endproperty
   a_reload_on_refresh: assert property (p_reload_on_refresh)
      else $error("refresh did not reload");

   property p_start;
      @(posedge sys_clk) disable iff (srst)
      wr_start && !boot |=> running;
   endproperty
   a_start: assert property (p_start)
      else $error("start write ignored");

   property p_protect_bit;
      @(posedge sys_clk) disable iff (srst)
      wr_protect && !boot |=> protect_mode_enable == $past(wdata[7]);
   endproperty
   a_protect_bit: assert property (p_protect_bit)
      else $error("protect bit not stored");

   property p_protect_hold;
      @(posedge sys_clk) disable iff (srst)
      running && protect_mode_enable && !osc_tick && !refresh_ok && !boot
      |=> $stable(count);
   endproperty
   a_protect_hold: assert property (p_protect_hold)
      else $error("count moved without source tick");

   property p_decrement;
      @(posedge sys_clk) disable iff (srst)
      dec && !underflow && !refresh_ok && !boot
      |=> count == $past(count) - 14'h0001;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("count did not decrement");

   property p_readout_plain;
      @(posedge sys_clk) disable iff (srst)
      rd_stb && addr == WDRW_OFF_READOUT && !protect_mode_enable
      |=> rdata == {2'h0, $past(count[10:5])};
   endproperty
   a_readout_plain: assert property (p_readout_plain)
      else $error("readout slice wrong");

   property p_readout_small;
      @(posedge sys_clk) disable iff (srst)
      rd_stb && addr == WDRW_OFF_READOUT && protect_mode_enable
      && reload_sel == 2'h0 |=> rdata == {2'h0, $past(count[5:0])};
   endproperty
   a_readout_small: assert property (p_readout_small)
      else $error("protect readout slice wrong");

   property p_boot;
      @(posedge sys_clk)
      boot && !srst |=> running == !$past(first_option_byte[0])
      && protect_mode_enable == !$past(first_option_byte[1])
      && count == $past(reload_val);
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot state wrong");

   // A refused refresh leaves the counter on its normal path: it moves
   // only by the one step that the count source allows.
   sequence s_outside_window;
      wr_refresh && !in_window && !boot;
   endsequence

   sequence s_second_unarmed;
      wr_refresh && wdata == WDRW_REFRESH_SECOND && !armed && !boot
      && !underflow;
   endsequence

   sequence s_count_kept;
      count == $past(count) - {13'h0000, $past(dec)};
   endsequence

   property p_window;
      @(posedge sys_clk) disable iff (srst)
      s_outside_window |=> s_count_kept;
   endproperty
   a_window: assert property (p_window)
      else $error("refresh outside window taken");

   property p_refresh_refused;
      @(posedge sys_clk) disable iff (srst)
      s_second_unarmed |=> s_count_kept;
   endproperty
   a_refresh_refused: assert property (p_refresh_refused)
      else $error("refresh without first byte taken");

   property p_readout_wide;
      @(posedge sys_clk) disable iff (srst)
      rd_stb && addr == WDRW_OFF_READOUT && protect_mode_enable
      && reload_sel != 2'h0
      |=> rdata == {2'h0,
                    6'($past(count) >> ({1'b0, $past(reload_sel)} + 3'h2))};
   endproperty
   a_readout_wide: assert property (p_readout_wide)
      else $error("wide protect readout slice wrong");

   property p_flag_clear;
      @(posedge sys_clk) disable iff (srst)
      wr_detect && wdata[WDRW_DETECT_BIT] && !underflow
      |=> !underflow_detect_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by writing one");

   property p_flag_hold;
      @(posedge sys_clk) disable iff (srst)
      !underflow && !(wr_detect && wdata[WDRW_DETECT_BIT])
      |=> $stable(underflow_detect_flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag changed without cause");

   property p_underflow_reload;
      @(posedge sys_clk) disable iff (srst)
      underflow |=> wdt_reset_req && count == $past(reload_val);
   endproperty
   a_underflow_reload: assert property (p_underflow_reload)
      else $error("underflow did not reload and request");

   property p_req_only;
      @(posedge sys_clk) disable iff (srst)
      !underflow |=> !wdt_reset_req;
   endproperty
   a_req_only: assert property (p_req_only)
      else $error("reset request without underflow");
endmodule : wdrw_watchdog

// File: verification/tb_top.sv
// Self-checking testbench for the windowed watchdog: start, readout,
// underflow flag, interrupt, refresh window and reload periods.
// Assumes the register port of wdrw_watchdog and a 125 MHz clock.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import wdrw_pkg::*;

   localparam int OSC_DIV = 4;
   logic        sys_clk     = 1'b0;
   logic        srst        = 1'b1;
   logic [19:0] addr        = 20'h00000;
   logic [7:0]  wdata       = 8'h00;
   logic        wr_stb      = 1'b0;
   logic        rd_stb      = 1'b0;
   logic [7:0]  opt_one     = 8'h03;
   logic [7:0]  opt_two     = 8'hf0;
   logic [7:0]  rdata;
   logic        wdt_reset_req;
   logic        irq;
   int          failures    = 0;
   int          comparisons = 0;
   int          cycles      = 0;
   int          n, w, lim, tot;
   logic [7:0]  one_tab [5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00};
   int          per_tab [5] = '{1024, 4096, 8192, 16384, 4096};

   always #4 sys_clk = ~sys_clk;

   wdrw_watchdog #(.OSC_DIV(OSC_DIV)) i_dut (
      .sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .first_option_byte(opt_one), .second_option_byte(opt_two),
      .wdt_reset_req(wdt_reset_req), .irq(irq));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [19:0] a, input logic [7:0] exp,
                     input string what);
      @(posedge sys_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1;
      check(rdata, exp, what);
   endtask : rd

   // Counts clock edges up to and including the next reset request pulse.
   task automatic wait_req(output int cnt);
      cnt = 0;
      do begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end while (wdt_reset_req !== 1'b1 && cnt < 20000);
      check(cnt < 20000, 1, "pulse wait");
   endtask : wait_req

   task automatic do_reset(input logic [7:0] o1, input logic [7:0] o2);
      @(posedge sys_clk);
      srst    <= 1'b1;
      opt_one <= o1;
      opt_two <= o2;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : do_reset

   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      do_reset(8'h03, 8'hf0);
      rd(WDRW_OFF_READOUT, 8'h1f, "stopped readout");
      repeat (20) @(posedge sys_clk);
      rd(WDRW_OFF_READOUT, 8'h1f, "still stopped");
      rd(20'h00100, 8'h00, "unmapped read");
      rd(WDRW_OFF_PROTECT, 8'h00, "protect off");
      wr(WDRW_OFF_PROTECT, 8'h80);
      rd(WDRW_OFF_READOUT, 8'h3f, "protect readout");
      rd(WDRW_OFF_PROTECT, 8'h80, "protect on");
      wr(WDRW_OFF_PROTECT, 8'h00);
      rd(WDRW_OFF_READOUT, 8'h1f, "plain readout");
      wr(WDRW_OFF_START, 8'h5a);
      repeat (45) @(posedge sys_clk);
      rd(WDRW_OFF_READOUT, 8'h1e, "counting readout");
      wait_req(n);
      check(irq, 1'b0, "masked irq");
      rd(WDRW_OFF_DETECT, 8'h08, "detect flag");
      wr(WDRW_OFF_IRQ_MASK, 8'h08);
      #1;
      check(irq, 1'b1, "unmasked irq");
      wr(WDRW_OFF_DETECT, 8'h08);
      #1;
      check(irq, 1'b0, "cleared irq");
      rd(WDRW_OFF_DETECT, 8'h00, "flag cleared");
      // Refresh just outside and just inside each window; the 100 percent
      // window is probed with a disarmed sequence instead.
      for (int d = 0; d < 4; d++) begin
         do_reset(8'h02, 8'hf0 | 8'(d << 2));
         wait_req(n);
         for (int acc = 0; acc < 2; acc++) begin
            lim = 1023 * (d + 1) / 4;
            w = (d == 3) ? 30 : 1023 - lim + (acc != 0 ? 30 : -30);
            repeat (w) @(posedge sys_clk);
            wr(WDRW_OFF_REFRESH, WDRW_REFRESH_FIRST);
            if (d == 3 && acc == 0) begin
               wr(WDRW_OFF_REFRESH, 8'h55);
            end
            wr(WDRW_OFF_REFRESH, WDRW_REFRESH_SECOND);
            wait_req(n);
            tot = w + n + ((d == 3 && acc == 0) ? 6 : 4);
            check(tot > 1040, acc, "refresh taken");
         end
      end
      for (int i = 0; i < 5; i++) begin
         do_reset(one_tab[i], (i < 4) ? (8'hf0 | 8'(i)) : 8'hf0);
         if (i == 4) begin
            rd(WDRW_OFF_PROTECT, 8'h80, "protect from reset");
         end
         wait_req(n);
         check(n >= per_tab[i] - 12 && n <= per_tab[i] + 8, 1,
               "underflow period");
         if (i > 0 && i < 4) begin
            // 62 plain steps after the reload, then protect mode is set;
            // the slice is the same whether or not one more tick follows.
            repeat (60) @(posedge sys_clk);
            wr(WDRW_OFF_PROTECT, 8'h80);
            tot = per_tab[i] - 63;
            rd(WDRW_OFF_READOUT, 8'((tot >> (i + 2)) & 63),
               "protect slice");
         end
      end
      give_verdict();
   end
endmodule : tb_top
